// ---- hw/ret_rot_pkg.sv ----
// Shared constants and carrier types for the return / rotate-right unit
package ret_rot_pkg;
  localparam int OPC_W  = 14;
  localparam int PC_W   = 13;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;

  localparam logic [13:0] RETURN_OPCODE  = 14'h0008;
  localparam logic [13:0] ROTATE_MASK    = 14'h3F00;
  localparam logic [13:0] ROTATE_PATTERN = 14'h0C00;
  localparam int          DEST_BIT       = 7;
  localparam int          RETURN_CYCLES  = 2;

  localparam logic [7:0]  DATA_RST = 8'h00;
  localparam logic [12:0] PC_RST   = 13'h0000;
  localparam logic [6:0]  ADDR_RST = 7'h00;

  // Request to the register file: write back after a rotate
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_wr_t;

  // Request to the return stack and program counter
  typedef struct packed {
    logic            pop;
    logic            load;
    logic [PC_W-1:0] target;
  } flow_t;

  typedef enum logic {ST_EXEC, ST_FLUSH} exec_state_t;
endpackage

// ---- hw/return_and_rotate_right_exec.sv ----
// Execute stage for subroutine return and rotate right through carry
// Notes on behaviour
// - Decode return opcode 0x0008; no operands, status flags untouched.
// - Return pops the stack and loads its top entry into the PC.
// - Return takes two cycles; second cycle discards the prefetched word.
// - Decode 00 1100 dfff ffff as rotate right of a register via carry.
// - The 7-bit address field selects any register 0 to 127.
// - Destination bit clear: result goes to accumulator, register untouched.
// - Destination bit set: result written back to the addressed register.
`timescale 1ns/1ps
module return_and_rotate_right_exec (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr_word,
  input  wire logic [12:0] stack_top_entry,
  input  wire logic [7:0]  file_rd_data,
  input  wire logic        carry_flag,
  output logic      [6:0]  file_rd_addr,
  output ret_rot_pkg::file_wr_t file_wr,
  output ret_rot_pkg::flow_t    flow,
  output logic      [7:0]  acc_data,
  output logic             acc_wr,
  output logic             carry_wr,
  output logic             carry_data,
  output logic             flush_fetch,
  output logic             busy
);
  ret_rot_pkg::exec_state_t state_ff;
  ret_rot_pkg::file_wr_t    file_wr_ff;
  ret_rot_pkg::flow_t       flow_ff;
  logic [7:0] acc_data_ff;
  logic       acc_wr_ff;
  logic       carry_wr_ff;
  logic       carry_data_ff;
  logic       flush_ff;
  logic       busy_ff;
  logic [7:0] rot_result;
  logic       rot_carry;
  logic       is_return;
  logic       is_rotate;
  logic       dest_file;

  // Decode only while not in the flush cycle of a return
  always_comb begin
    is_return = instr_valid && state_ff == ret_rot_pkg::ST_EXEC
                && instr_word == ret_rot_pkg::RETURN_OPCODE;
    is_rotate = instr_valid && state_ff == ret_rot_pkg::ST_EXEC
                && (instr_word & ret_rot_pkg::ROTATE_MASK)
                   == ret_rot_pkg::ROTATE_PATTERN;
    dest_file = instr_word[ret_rot_pkg::DEST_BIT];
  end

  // Register file read address is the raw field, full 0..127 range
  always_comb begin
    file_rd_addr = instr_word[ret_rot_pkg::ADDR_W-1:0];
  end

  rotate_right_alu u_alu (
    .operand   (file_rd_data),
    .carry_in  (carry_flag),
    .result    (rot_result),
    .carry_out (rot_carry)
  );

  // Return sequencing: one execute cycle then one flush cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ret_rot_pkg::ST_EXEC;
    end else begin
      unique case (state_ff)
        ret_rot_pkg::ST_EXEC: begin
          if (is_return) begin
            state_ff <= ret_rot_pkg::ST_FLUSH;
          end
        end
        ret_rot_pkg::ST_FLUSH: begin
          state_ff <= ret_rot_pkg::ST_EXEC;
        end
      endcase
    end
  end

  // Stack pop and PC load
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flow_ff  <= '{pop: 1'h0, load: 1'h0, target: ret_rot_pkg::PC_RST};
      flush_ff <= 1'h0;
    end else begin
      flow_ff.pop    <= is_return;
      flow_ff.load   <= is_return;
      flow_ff.target <= is_return ? stack_top_entry : flow_ff.target;
      flush_ff       <= is_return;
    end
  end

  // Busy has a flop of its own so the port carries no decode gate
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_ff <= 1'h0;
    end else begin
      busy_ff <= is_return;
    end
  end

  // Accumulator path; the data field holds between rotates
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_data_ff <= ret_rot_pkg::DATA_RST;
      acc_wr_ff   <= 1'h0;
    end else begin
      acc_wr_ff <= is_rotate && !dest_file;
      if (is_rotate) begin
        acc_data_ff <= rot_result;
      end
    end
  end

  // Register file write-back port
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      file_wr_ff <= '{wr: 1'h0, addr: ret_rot_pkg::ADDR_RST,
                      data: ret_rot_pkg::DATA_RST};
    end else begin
      file_wr_ff.wr <= is_rotate && dest_file;
      if (is_rotate) begin
        file_wr_ff.addr <= instr_word[ret_rot_pkg::ADDR_W-1:0];
        file_wr_ff.data <= rot_result;
      end
    end
  end

  // Carry leaves as a request; the core owns the flag and commits it,
  // which keeps a return from ever disturbing it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      carry_wr_ff   <= 1'h0;
      carry_data_ff <= 1'h0;
    end else begin
      carry_wr_ff <= is_rotate;
      if (is_rotate) begin
        carry_data_ff <= rot_carry;
      end
    end
  end

  always_comb begin
    file_wr     = file_wr_ff;
    flow        = flow_ff;
    acc_data    = acc_data_ff;
    acc_wr      = acc_wr_ff;
    carry_wr    = carry_wr_ff;
    carry_data  = carry_data_ff;
    flush_fetch = flush_ff;
    busy        = busy_ff;
  end

  // Checks; a refused word must leave the pop, carry, accumulator and file write strobes low one cycle on
  chk_return_pops: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    is_return |=> flow.pop && flow.load
      && flow.target == $past(stack_top_entry))
    else $error("return did not pop stack into pc");

  chk_target_held: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !is_return |=> !flow.pop && !flow.load && $stable(flow.target))
    else $error("stack pop or pc target moved without a return");

  chk_return_flush: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    is_return |=> flush_fetch && busy ##1 !flush_fetch && !busy)
    else $error("return did not flush exactly one cycle");

  chk_flush_ignores: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    busy |=> !flow.pop && !carry_wr && !acc_wr && !file_wr.wr)
    else $error("instruction executed during flush");

  chk_return_no_flags: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    is_return |=> !carry_wr && !acc_wr && !file_wr.wr)
    else $error("return touched flags or data");

  chk_other_ignored: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    instr_valid && !busy && instr_word != ret_rot_pkg::RETURN_OPCODE
      && (instr_word & ret_rot_pkg::ROTATE_MASK)
         != ret_rot_pkg::ROTATE_PATTERN
    |=> !flow.pop && !carry_wr && !acc_wr && !file_wr.wr)
    else $error("unknown opcode was executed");

  chk_rot_addr: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    is_rotate |-> file_rd_addr == instr_word[ret_rot_pkg::ADDR_W-1:0])
    else $error("rotate operand address wrong");

  chk_rot_to_acc: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    is_rotate && !dest_file |=> acc_wr && !file_wr.wr
      && acc_data == {$past(carry_flag),
                      $past(file_rd_data[ret_rot_pkg::DATA_W-1:1])})
    else $error("rotate to accumulator wrong");

  chk_acc_held: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !is_rotate |=> !acc_wr && $stable(acc_data))
    else $error("accumulator written without a rotate");

  chk_rot_to_file: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    is_rotate && dest_file |=> file_wr.wr && !acc_wr
      && file_wr.addr == $past(instr_word[ret_rot_pkg::ADDR_W-1:0])
      && file_wr.data == {$past(carry_flag),
                          $past(file_rd_data[ret_rot_pkg::DATA_W-1:1])})
    else $error("rotate write-back wrong");

  chk_rot_carry: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    is_rotate |=> carry_wr && carry_data == $past(file_rd_data[0]))
    else $error("rotate carry wrong");

  chk_carry_held: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !is_rotate |=> !carry_wr && $stable(carry_data))
    else $error("carry written without a rotate");

  cov_return: cover property (@(posedge sys_clk) disable iff (sys_rst)
    is_return ##2 is_rotate);
  cov_rot_acc: cover property (@(posedge sys_clk) disable iff (sys_rst)
    is_rotate && !dest_file && carry_flag);
  cov_rot_file: cover property (@(posedge sys_clk) disable iff (sys_rst)
    is_rotate && dest_file && (&file_rd_addr));
  cov_flush_drop: cover property (@(posedge sys_clk) disable iff (sys_rst)
    busy && instr_valid);
endmodule

// ---- hw/rotate_right_alu.sv ----
// Combinational rotate-right-through-carry datapath
`timescale 1ns/1ps
module rotate_right_alu (
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic            carry_out
);
  always_comb begin
    result    = {carry_in, operand[7:1]};
    carry_out = operand[0];
  end
endmodule

// ---- tb/test_return_and_rotate_right_exec.sv ----
// Self-checking bench for the return / rotate-right execute unit
`timescale 1ns/1ps
module test_return_and_rotate_right_exec;
  logic                  sys_clk, sys_rst, instr_valid, carry_flag;
  logic [13:0]           instr_word;
  logic [12:0]           stack_top_entry;
  logic [7:0]            file_rd_data, acc_data;
  logic [6:0]            file_rd_addr;
  ret_rot_pkg::file_wr_t file_wr;
  ret_rot_pkg::flow_t    flow;
  logic                  acc_wr, carry_wr, carry_data, flush_fetch, busy;
  int                    miscompares, num_checks, cycles;

  return_and_rotate_right_exec u_return_and_rotate_right_exec (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .stack_top_entry(stack_top_entry),
    .file_rd_data(file_rd_data), .carry_flag(carry_flag),
    .file_rd_addr(file_rd_addr), .file_wr(file_wr), .flow(flow),
    .acc_data(acc_data), .acc_wr(acc_wr), .carry_wr(carry_wr),
    .carry_data(carry_data), .flush_fetch(flush_fetch), .busy(busy));

  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Write, pop and load strobes must all be quiet when nothing was accepted
  task automatic quiet;
    compare({acc_wr, file_wr.wr, carry_wr}, 16'h0000);
    compare({flow.pop, flow.load}, 16'h0000);
  endtask

  task automatic rotate(input logic d, input logic [6:0] f,
                        input logic [7:0] v, input logic c);
    @(negedge sys_clk);
    instr_valid  = 1'h1;
    instr_word   = {2'h0, 4'hC, d, f};
    file_rd_data = v;
    carry_flag   = c;
    #1 compare(file_rd_addr, f);
    @(negedge sys_clk);
    instr_valid = 1'h0;
    compare({carry_wr, carry_data}, {15'h0001, v[0]});
    compare({acc_wr, file_wr.wr}, {!d, d});
    if (d) compare({file_wr.addr, file_wr.data}, {f, c, v[7:1]});
    else compare(acc_data, {c, v[7:1]});
    compare({flow.pop, busy, flush_fetch}, 16'h0000);
  endtask

  // Return; a rotate held over the flush cycle is dropped, then taken
  task automatic do_return(input logic [12:0] top);
    @(negedge sys_clk);
    instr_valid     = 1'h1;
    instr_word      = 14'h0008;
    stack_top_entry = top;
    @(negedge sys_clk);
    instr_word   = 14'h0C85;
    file_rd_data = 8'h3C;
    carry_flag   = 1'h1;
    compare({flow.pop, flow.load, flow.target}, {2'h3, top});
    compare({flush_fetch, busy, carry_wr, acc_wr}, 16'h000C);
    @(negedge sys_clk);
    quiet();
    compare({flush_fetch, busy}, 16'h0000);
    @(negedge sys_clk);
    instr_valid = 1'h0;
    compare({file_wr.wr, file_wr.addr, file_wr.data}, 16'h859E);
    compare({carry_wr, carry_data, flow.pop}, 16'h0004);
  endtask

  task automatic ignored(input logic [13:0] w, input logic v);
    @(negedge sys_clk);
    instr_valid = v;
    instr_word  = w;
    @(negedge sys_clk);
    instr_valid = 1'h0;
    quiet();
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Whole run needs well under the 2000-cycle limit
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    sys_rst = 1'h1;
    instr_valid = 1'h0;
    instr_word = 14'h0000;
    stack_top_entry = 13'h0000;
    file_rd_data = 8'h00;
    carry_flag = 1'h0;
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'h0;
    rotate(1'h0, 7'h05, 8'hE6, 1'h0);
    rotate(1'h1, 7'h7F, 8'h01, 1'h1);
    rotate(1'h1, 7'h00, 8'h5A, 1'h0);
    do_return(13'h1ABC);
    do_return(13'h0543);
    ignored(14'h0009, 1'h1);
    ignored(14'h0D05, 1'h1);
    ignored(14'h0008, 1'h0);
    rotate(1'h0, 7'h40, 8'h81, 1'h1);
    complete_run();
  end
endmodule
